/* rtl/rcs_ctrl_status.sv */
// control/status, aging and temperature registers of the rtc
// assumes a bus engine on core_clk giving byte writes and reads,
// a temperature sensor and timekeeping on core_clk, and the crystal
// clock, supply state and crystal fault arriving asynchronously
`timescale 1ns/1ps
module rcs_ctrl_status
  import rcs_pkg::*;
#(
  parameter int DELAY_CYC = USER_DELAY_CYC
) (
  input  wire logic       core_clk,        // block clock, 250 MHz
  input  wire logic       resetn,          // power-on reset, low
  input  wire logic [7:0] reg_addr,        // register offset
  input  wire logic       reg_wr,          // write strobe
  input  wire logic       reg_rd,          // read strobe
  input  wire logic [7:0] reg_wdata,       // write byte
  output logic      [7:0] reg_rdata,       // read byte, next cycle
  input  wire logic       osc_clk_in,      // crystal clock, async
  input  wire logic       on_battery,      // supply below fail, async
  input  wire logic       osc_fault,       // crystal disturbed, async
  input  wire logic       second_tick,     // time registers update
  input  wire logic       alarm_one_match, // alarm 1 compare hit
  input  wire logic       alarm_two_match, // alarm 2 compare hit
  output logic            temp_temp_convert_request_req,   // sensor start, level
  input  wire logic       temp_done,       // sensor finished pulse
  input  wire logic [9:0] temp_result,     // sensor code
  output logic            comp_apply,      // capacitance update pulse
  output logic      [7:0] aging_trim,      // signed trim to array
  output logic            osc_enable,      // crystal run enable
  output logic            irq_or_wave_pin, // shared pin drive level
  output logic            irq_or_wave_oe,  // shared pin drive enable
  output logic            ref_out          // 32kHz output pin
);

  // synchronisers: stage 1 feeds only stage 2
  logic [1:0] osc_s;
  logic       osc_prev;
  logic [1:0] bat_s;
  logic [1:0] flt_s;

  // two flops before any logic looks at pin levels
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      osc_s    <= 2'h0;
      osc_prev <= 1'b0;
      bat_s    <= 2'h0;
      flt_s    <= 2'h0;
    end else begin
      osc_s    <= {osc_s[0], osc_clk_in};
      osc_prev <= osc_s[1];
      bat_s    <= {bat_s[0], on_battery};
      flt_s    <= {flt_s[0], osc_fault};
    end
  end

  logic bat;
  logic osc_rise;
  assign bat      = bat_s[1];
  assign osc_rise = osc_s[1] & ~osc_prev;

  // state of the main group
  rcs_ctrl_s        ctrl;
  rcs_stat_s        stat;
  logic [7:0]       aging;
  logic [9:0]       temp;
  logic [DIV_W-1:0] div;
  logic [SEC_W-1:0] sec_cnt;
  logic [SEC_W-1:0] cur_iv;
  logic             auto_pend;
  rcs_temp_convert_request_e        cv_state;
  logic [31:0]      wait_cnt;
  logic             req;
  logic             apply;
  logic [7:0]       rdata;
  logic             osc_en;
  logic             pin_out;
  logic             pin_oe;
  logic             ref_q;

  rcs_ctrl_s        next_ctrl;
  rcs_stat_s        next_stat;
  logic [7:0]       next_aging;
  logic [9:0]       next_temp;
  logic [DIV_W-1:0] next_div;
  logic [SEC_W-1:0] next_sec_cnt;
  logic [SEC_W-1:0] next_cur_iv;
  logic             next_auto_pend;
  rcs_temp_convert_request_e        next_cv_state;
  logic [31:0]      next_wait_cnt;
  logic             next_req;
  logic             next_apply;
  logic [7:0]       next_rdata;
  logic             next_osc_en;
  logic             next_pin_out;
  logic             next_pin_oe;
  logic             next_ref_q;

  // helpers
  logic             osc_on;
  logic             sec_wrap;
  logic             wr_ctrl;
  logic             wr_stat;
  logic             sq_wave;
  logic             irq_act;
  logic [1:0]       rs_code;
  logic [1:0]       cr_code;

  // oscillator runs unless disabled on battery or disturbed
  assign osc_on = ~(bat & ctrl.osc_disable_on_battery)
                & ~flt_s[1];
  assign sec_wrap = osc_rise & osc_on & (&div);
  assign wr_ctrl  = reg_wr & (reg_addr == ADDR_CTRL);
  assign wr_stat  = reg_wr & (reg_addr == ADDR_STAT);
  assign rs_code  = {ctrl.square_rate_sel_hi, ctrl.square_rate_sel_lo};
  assign cr_code  = {stat.comp_rate_sel_hi, stat.comp_rate_sel_lo};

  // square-wave rate select off the crystal divider
  always_comb begin
    case (rs_code)
      2'h0:    sq_wave = div[TAP_1HZ];
      2'h1:    sq_wave = div[TAP_1K];
      2'h2:    sq_wave = div[TAP_4K];
      default: sq_wave = div[TAP_8K];
    endcase
  end

  // alarm flags only reach the pin when enabled and selected
  assign irq_act = ctrl.irq_not_square_select
                 & ((stat.alarm_two_flag & ctrl.alarm_two_irq_enable)
                 |  (stat.alarm_one_flag & ctrl.alarm_one_irq_enable));

  // next values of registers, timers, conversion and pins
  always_comb begin
    next_ctrl      = ctrl;
    next_stat      = stat;
    next_aging     = aging;
    next_temp      = temp;
    next_div       = div;
    next_sec_cnt   = sec_cnt;
    next_cur_iv    = cur_iv;
    next_auto_pend = auto_pend;
    next_cv_state  = cv_state;
    next_wait_cnt  = wait_cnt;
    next_req       = req;
    next_apply     = 1'b0;
    next_rdata     = rdata;
    next_osc_en    = ~(bat & ctrl.osc_disable_on_battery);

    // divider only counts real crystal edges while running
    if (osc_rise && osc_on) begin
      next_div = div + 1'b1;
    end

    // automatic interval: rate change lands at next wrap
    if (sec_wrap) begin
      if (sec_cnt + 1'b1 >= cur_iv) begin
        next_sec_cnt   = '0;
        next_auto_pend = 1'b1;
        next_cur_iv    = COMP_BASE_S << cr_code;
      end else begin
        next_sec_cnt = sec_cnt + 1'b1;
      end
    end

    // register writes; result registers take none
    if (wr_ctrl) begin
      next_ctrl = rcs_ctrl_s'(reg_wdata);
      next_ctrl.temp_convert_request = ctrl.temp_convert_request;
    end
    if (wr_stat) begin
      next_stat.battery_ref_out_enable = reg_wdata[6];
      next_stat.comp_rate_sel_hi       = reg_wdata[5];
      next_stat.comp_rate_sel_lo       = reg_wdata[4];
      next_stat.ref_out_enable         = reg_wdata[3];
      // flags only clear on a written 0
      if (!reg_wdata[7]) begin
        next_stat.osc_stopped_flag = 1'b0;
      end
      if (!reg_wdata[1]) begin
        next_stat.alarm_two_flag = 1'b0;
      end
      if (!reg_wdata[0]) begin
        next_stat.alarm_one_flag = 1'b0;
      end
    end
    if (reg_wr && reg_addr == ADDR_AGING) begin
      next_aging = reg_wdata;
    end

    // hardware sets win over a clearing write in the same cycle
    if (!osc_on) begin
      next_stat.osc_stopped_flag = 1'b1;
    end
    if (second_tick && osc_on) begin
      if (alarm_two_match) begin
        next_stat.alarm_two_flag = 1'b1;
      end
      if (alarm_one_match) begin
        next_stat.alarm_one_flag = 1'b1;
      end
    end

    // conversion sequencer
    case (cv_state)
      CV_IDLE: begin
        if (auto_pend && osc_on) begin
          next_auto_pend = 1'b0;
          next_req       = 1'b1;
          next_stat.compensation_busy = 1'b1;
          next_cv_state  = CV_BUSY;
        end else if (wr_ctrl && reg_wdata[5] && osc_on
                     && !stat.compensation_busy) begin
          next_ctrl.temp_convert_request = 1'b1;
          next_wait_cnt = '0;
          next_cv_state = CV_USER_WAIT;
        end
      end
      CV_USER_WAIT: begin
        // busy stays low while the user start settles
        if (wait_cnt >= 32'(DELAY_CYC - 1)) begin
          next_req      = 1'b1;
          next_stat.compensation_busy = 1'b1;
          next_cv_state = CV_BUSY;
        end else begin
          next_wait_cnt = wait_cnt + 32'h1;
        end
      end
      CV_BUSY: begin
        if (temp_done) begin
          next_req   = 1'b0;
          next_apply = 1'b1;
          next_temp  = temp_result;
          next_stat.compensation_busy    = 1'b0;
          next_ctrl.temp_convert_request = 1'b0;
          next_cv_state = CV_IDLE;
        end
      end
      default: begin
        next_req      = 1'b0;
        next_cv_state = CV_IDLE;
      end
    endcase

    // read port, unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:      next_rdata = ctrl;
        ADDR_STAT:      next_rdata = stat;
        ADDR_AGING:     next_rdata = aging;
        ADDR_TEMP_INT:  next_rdata = temp[9:FRAC_W];
        ADDR_TEMP_FRAC: next_rdata = {temp[FRAC_W-1:0], 6'h00};
        default:        next_rdata = 8'h00;
      endcase
    end

    // shared pin: square wave push-pull, interrupt open-drain
    if (ctrl.irq_not_square_select) begin
      next_pin_out = 1'b0;
      next_pin_oe  = irq_act;
    end else begin
      next_pin_out = sq_wave;
      next_pin_oe  = ~bat | ctrl.battery_square_wave_enable;
    end

    // 32kHz reference gated by enables and a running crystal
    next_ref_q = stat.ref_out_enable
               & (~bat | stat.battery_ref_out_enable)
               & osc_on & osc_s[1];
  end

  // registers of the main group; reset is the power-on state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl      <= CTRL_RST;
      stat      <= STAT_RST;
      aging     <= AGING_RST;
      temp      <= TEMP_RST;
      div       <= '0;
      sec_cnt   <= '0;
      cur_iv    <= COMP_BASE_S;
      auto_pend <= 1'b1;
      cv_state  <= CV_IDLE;
      wait_cnt  <= 32'h0;
      req       <= 1'b0;
      apply     <= 1'b0;
      rdata     <= 8'h00;
      osc_en    <= 1'b1;
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
      ref_q     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      stat      <= next_stat;
      aging     <= next_aging;
      temp      <= next_temp;
      div       <= next_div;
      sec_cnt   <= next_sec_cnt;
      cur_iv    <= next_cur_iv;
      auto_pend <= next_auto_pend;
      cv_state  <= next_cv_state;
      wait_cnt  <= next_wait_cnt;
      req       <= next_req;
      apply     <= next_apply;
      rdata     <= next_rdata;
      osc_en    <= next_osc_en;
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      ref_q     <= next_ref_q;
    end
  end

  // outputs straight from flops
  assign reg_rdata       = rdata;
  assign temp_temp_convert_request_req   = req;
  assign comp_apply      = apply;
  assign aging_trim      = aging;
  assign osc_enable      = osc_en;
  assign irq_or_wave_pin = pin_out;
  assign irq_or_wave_oe  = pin_oe;
  assign ref_out         = ref_q;

endmodule

/* rtl/rcs_pkg.sv */
// constants, field layouts and types of the rtc control/status block
// assumes a serial bus engine on core_clk and async pins synced there
// Notes on behaviour
// - oscillator always on with main supply; disable bit acts on battery
// - while disabled oscillator is stopped, counters and alarm flags stay static
// - on battery, square wave drives pin only if enabled and select 0
// - convert bit starts conversion and compensation unless one runs
// - user conversions leave automatic interval timing untouched
// - busy may lag a user start by about 2ms; not used for progress
// - convert bit reads 1 until done, then convert and busy clear together
// - rate bits pick 1Hz, 1.024kHz, 4.096kHz, 8.192kHz; both reset to 1
// - select 0 gives square wave; select 1 gives active-low interrupt
// - alarm match sets its flag regardless of select and enables
// - alarm 2 flag interrupts only with its enable and select both 1
// - alarm 1 flag interrupts only with its enable and select both 1
// - oscillator-stop flag sets whenever oscillator stops, power-up too
// - oscillator-stop flag stays set until software writes 0
// - on battery, 32kHz output needs both enables, else low
// - conversion-rate bits pick 64, 128, 256 or 512 second interval
// - new conversion rate may take one full old interval to apply
// - 32kHz output enable gives 32.768kHz wave while running, else low
// - busy rises with sensor request and falls on conversion complete
// - alarm 2 flag set on match, cleared only by writing 0
// - alarm 1 flag set on match, cleared only by writing 0
// - alarm matches evaluated once per second at time update
// - temperature is 10-bit two's complement, quarter degree steps
// - aging trim is signed byte added to compensation value
// - writes to temperature result registers are ignored
package rcs_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h0e;
  localparam logic [7:0] ADDR_STAT      = 8'h0f;
  localparam logic [7:0] ADDR_AGING     = 8'h10;
  localparam logic [7:0] ADDR_TEMP_INT  = 8'h11;
  localparam logic [7:0] ADDR_TEMP_FRAC = 8'h12;

  // clock_control, msb first as in the register
  typedef struct packed {
    logic osc_disable_on_battery;
    logic battery_square_wave_enable;
    logic temp_convert_request;
    logic square_rate_sel_hi;
    logic square_rate_sel_lo;
    logic irq_not_square_select;
    logic alarm_two_irq_enable;
    logic alarm_one_irq_enable;
  } rcs_ctrl_s;

  // clock_control_status, msb first as in the register
  typedef struct packed {
    logic osc_stopped_flag;
    logic battery_ref_out_enable;
    logic comp_rate_sel_hi;
    logic comp_rate_sel_lo;
    logic ref_out_enable;
    logic compensation_busy;
    logic alarm_two_flag;
    logic alarm_one_flag;
  } rcs_stat_s;

  localparam rcs_ctrl_s  CTRL_RST  = 8'h1c;
  localparam rcs_stat_s  STAT_RST  = 8'hc8;
  localparam logic [7:0] AGING_RST = 8'h00;
  localparam logic [9:0] TEMP_RST  = 10'h000;
  localparam int         FRAC_W    = 2;

  // oscillator divider, taps for rate codes 0..3
  localparam int DIV_W     = 15;
  localparam int TAP_1HZ   = 14;
  localparam int TAP_1K    = 4;
  localparam int TAP_4K    = 2;
  localparam int TAP_8K    = 1;

  // compensation interval base, seconds
  localparam int         SEC_W       = 10;
  localparam logic [9:0] COMP_BASE_S = 10'h040;

  // user conversion lag before the sensor request
  localparam int CLK_PERIOD_NS  = 4;
  localparam int USER_DELAY_US  = 2000;
  localparam int USER_DELAY_CYC = USER_DELAY_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {CV_IDLE, CV_USER_WAIT, CV_BUSY} rcs_temp_convert_request_e;

endpackage

/* verification/rcs_ctrl_status_asserts.sv */
// port checker for the rtc control/status block
// assumes one-cycle register strobes and the sensor link of the bench
`timescale 1ns/1ps
module rcs_ctrl_status_asserts
  import rcs_pkg::*;
#(
  parameter int DELAY_CYC = 16
) (
  input wire logic       core_clk,        // block clock
  input wire logic       resetn,          // reset, low
  input wire logic [7:0] reg_addr,        // register offset
  input wire logic       reg_wr,          // write strobe
  input wire logic       reg_rd,          // read strobe
  input wire logic [7:0] reg_wdata,       // write byte
  input wire logic [7:0] reg_rdata,       // read byte
  input wire logic       on_battery,      // supply state
  input wire logic       temp_temp_convert_request_req,   // sensor start
  input wire logic       temp_done,       // sensor finished
  input wire logic       comp_apply,      // capacitance update
  input wire logic [7:0] aging_trim,      // trim to array
  input wire logic       osc_enable,      // crystal run enable
  input wire logic       irq_or_wave_pin, // shared pin level
  input wire logic       irq_or_wave_oe   // shared pin enable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // sensor handshake: request holds until done, then one apply pulse
  a_done_drops_req: assert property (temp_temp_convert_request_req && temp_done |=>
    !temp_temp_convert_request_req && comp_apply) else $error("request not ended by done");
  a_req_holds: assert property (temp_temp_convert_request_req && !temp_done |=>
    temp_temp_convert_request_req) else $error("request dropped early");
  a_apply_pulse: assert property (comp_apply |=> !comp_apply)
    else $error("apply longer than one cycle");
  a_apply_cause: assert property ($rose(comp_apply) |->
    $past(temp_done) && $past(temp_temp_convert_request_req)) else $error("apply uncaused");
  // sync chain plus output register settle within six cycles
  a_osc_on_main: assert property ((!on_battery)[*6] |-> osc_enable)
    else $error("oscillator off on main supply");
  a_busy_read: assert property (reg_rd && reg_addr == ADDR_STAT |=>
    reg_rdata[2] == $past(temp_temp_convert_request_req)) else $error("busy read wrong");
  a_frac_low_zero: assert property (reg_rd &&
    reg_addr == ADDR_TEMP_FRAC |=> reg_rdata[5:0] == 6'h00)
    else $error("fraction low bits set");
  a_aging_copy: assert property (reg_wr && reg_addr == ADDR_AGING |->
    ##2 aging_trim == $past(reg_wdata, 2)) else $error("aging not copied");

  c_temp_convert_request_done: cover property (temp_temp_convert_request_req && temp_done);
  c_irq_low: cover property (irq_or_wave_oe && !irq_or_wave_pin);
  c_osc_stop: cover property (!osc_enable);
endmodule

bind rcs_ctrl_status rcs_ctrl_status_asserts #(.DELAY_CYC(DELAY_CYC)) chk_i (
  .core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .on_battery, .temp_temp_convert_request_req, .temp_done, .comp_apply, .aging_trim,
  .osc_enable, .irq_or_wave_pin, .irq_or_wave_oe);

/* verification/rcs_ctrl_status_test.sv */
// self-checking bench for the rtc control/status block
// assumes the sensor model and the bound port checker
`timescale 1ns/1ps
module rcs_ctrl_status_test;
  import rcs_pkg::*;
  logic       core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic       osc_clk_in = 0, on_battery = 0, osc_fault = 0;
  logic       second_tick = 0, alarm_one_match = 0, alarm_two_match = 0;
  logic       temp_done, temp_temp_convert_request_req, comp_apply, osc_enable, ref_out;
  logic       irq_or_wave_pin, irq_or_wave_oe;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, aging_trim;
  logic [9:0] temp_result, code = 10'h065;
  int         err_count = 0, total_checks = 0, cyc = 0, hits, sq_hits;

  rcs_ctrl_status #(.DELAY_CYC(16)) uut (.core_clk, .resetn, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .osc_clk_in, .on_battery,
    .osc_fault, .second_tick, .alarm_one_match, .alarm_two_match,
    .temp_temp_convert_request_req, .temp_done, .temp_result, .comp_apply, .aging_trim,
    .osc_enable, .irq_or_wave_pin, .irq_or_wave_oe, .ref_out);
  rcs_sensor_model #(.LAT(20)) sensor (.core_clk, .temp_temp_convert_request_req, .code,
    .temp_done, .temp_result);

  initial forever #2 core_clk = ~core_clk;
  // crystal is unrelated in phase to the block clock
  initial forever #62.5 osc_clk_in = ~osc_clk_in;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    wait_n(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    wait_n(1);
    reg_rd = 1'b0;
    chk(what, exp, reg_rdata);
  endtask
  // bounded wait on the sensor request level
  task automatic wait_req(input logic lvl);
    for (int n = 0; n < 300 && temp_temp_convert_request_req !== lvl; n++) wait_n(1);
    chk("request", {7'h00, lvl}, {7'h00, temp_temp_convert_request_req});
  endtask
  task automatic tick(input logic m1, input logic m2);
    @(posedge core_clk) #1;
    second_tick = 1'b1;
    alarm_one_match = m1;
    alarm_two_match = m2;
    wait_n(1);
    second_tick = 1'b0;
    alarm_one_match = 1'b0;
    alarm_two_match = 1'b0;
  endtask
  task automatic count_ref();
    hits = 0;
    sq_hits = 0;
    wait_n(4);
    repeat (100) begin
      wait_n(1);
      if (ref_out !== 1'b0) hits++;
      if (irq_or_wave_pin !== 1'b0) sq_hits++;
    end
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1 resetn = 1'b1;
    wait_req(1'b1);
    wait_req(1'b0);
    rd(ADDR_CTRL, 8'h1c, "control reset");
    rd(ADDR_STAT, 8'hc8, "status reset");
    rd(ADDR_TEMP_INT, 8'h19, "temp int");
    rd(ADDR_TEMP_FRAC, 8'h40, "temp frac");
    $display("reset test done");
    wr(ADDR_STAT, 8'hcf);
    rd(ADDR_STAT, 8'hc8, "status ones");
    wr(ADDR_STAT, 8'h48);
    rd(ADDR_STAT, 8'h48, "stop flag cleared");
    wr(ADDR_AGING, 8'h85);
    wr(ADDR_TEMP_INT, 8'haa);
    wr(8'h13, 8'h55);
    rd(ADDR_AGING, 8'h85, "aging");
    chk("aging out", 8'h85, aging_trim);
    rd(ADDR_TEMP_INT, 8'h19, "temp read only");
    rd(8'h13, 8'h00, "unmapped");
    $display("register test done");
    code = 10'h3e6;
    rd(ADDR_STAT, 8'h48, "busy before start");
    wr(ADDR_CTRL, 8'h3c);
    rd(ADDR_CTRL, 8'h3c, "convert set");
    rd(ADDR_STAT, 8'h48, "busy lag");
    wait_req(1'b1);
    rd(ADDR_STAT, 8'h4c, "busy high");
    wait_req(1'b0);
    rd(ADDR_CTRL, 8'h1c, "convert cleared");
    rd(ADDR_STAT, 8'h48, "busy cleared");
    rd(ADDR_TEMP_INT, 8'hf9, "new temp int");
    rd(ADDR_TEMP_FRAC, 8'h80, "new temp frac");
    $display("conversion test done");
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, 8'h04);
      tick(i == 0, i == 1);
      rd(ADDR_STAT, 8'h48 | (8'h01 << i), "alarm flag");
      chk("irq masked", 8'h00, {7'h00, irq_or_wave_oe});
      wr(ADDR_CTRL, 8'h04 | (8'h01 << i));
      wait_n(3);
      chk("irq drive", 8'h01, {7'h00, irq_or_wave_oe});
      chk("irq level", 8'h00, {7'h00, irq_or_wave_pin});
      wr(ADDR_STAT, 8'h4b);
      rd(ADDR_STAT, 8'h48 | (8'h01 << i), "flag kept");
      wr(ADDR_STAT, 8'h48);
      wait_n(3);
      chk("irq released", 8'h00, {7'h00, irq_or_wave_oe});
    end
    $display("alarm test done");
    wr(ADDR_CTRL, 8'h00);
    wait_n(3);
    chk("square drive", 8'h01, {7'h00, irq_or_wave_oe});
    on_battery = 1'b1;
    wait_n(8);
    chk("battery square off", 8'h00, {7'h00, irq_or_wave_oe});
    wr(ADDR_CTRL, 8'h40);
    wait_n(3);
    chk("battery square on", 8'h01, {7'h00, irq_or_wave_oe});
    wr(ADDR_STAT, 8'h08);
    count_ref();
    chk("ref off on battery", 8'h00, hits[7:0]);
    chk("square 1Hz still", 8'h00, sq_hits[7:0]);
    wr(ADDR_STAT, 8'h48);
    count_ref();
    chk("ref running", 8'h01, {7'h00, hits > 0});
    wr(ADDR_CTRL, 8'h58);
    count_ref();
    chk("square fast", 8'h01, {7'h00, sq_hits > 0});
    $display("output test done");
    wr(ADDR_CTRL, 8'hc0);
    wait_n(4);
    chk("osc stopped", 8'h00, {7'h00, osc_enable});
    rd(ADDR_STAT, 8'hc8, "stop flag set");
    tick(1'b1, 1'b1);
    rd(ADDR_STAT, 8'hc8, "frozen flags");
    on_battery = 1'b0;
    wait_n(8);
    chk("osc on main", 8'h01, {7'h00, osc_enable});
    rd(ADDR_STAT, 8'hc8, "stop flag held");
    wr(ADDR_STAT, 8'h48);
    rd(ADDR_STAT, 8'h48, "stop flag written 0");
    osc_fault = 1'b1;
    wait_n(4);
    osc_fault = 1'b0;
    wait_n(4);
    rd(ADDR_STAT, 8'hc8, "stop flag on fault");
    $display("oscillator test done");
    close_out();
  end
endmodule

/* verification/rcs_sensor_model.sv */
// temperature sensor model answering the conversion request
// assumes request is a level held until done is taken
`timescale 1ns/1ps
module rcs_sensor_model #(
  parameter int LAT = 20
) (
  input  wire logic       core_clk,      // block clock
  input  wire logic       temp_temp_convert_request_req, // start level
  input  wire logic [9:0] code,          // code to report
  output logic            temp_done,     // one-cycle finish
  output logic      [9:0] temp_result    // code, valid with done
);
  int cnt = 0;
  initial temp_done = 1'b0;
  initial temp_result = 10'h000;
  // result shows inverted outside done so stale data never matches
  always @(posedge core_clk) begin
    #1;
    if (temp_done) begin
      temp_done = 1'b0;
      temp_result = ~code;
      cnt = 0;
    end else if (temp_temp_convert_request_req === 1'b1) begin
      cnt++;
      if (cnt == LAT) begin
        temp_done = 1'b1;
        temp_result = code;
      end
    end
  end
endmodule
